// ==== common/bfp_defs.svh ====
// Constants for the bridge fault-protection block: register map, field
// positions, reset values and protection timing.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef BFP_DEFS_SVH
`define BFP_DEFS_SVH

// Register byte offsets
`define BFP_REG_CONTROL       8'h00
`define BFP_REG_STATUS        8'h04
`define BFP_REG_OVERLOAD_CNT  8'h08
`define BFP_ADDR_W            8

// Control register fields and reset value
`define BFP_CTRL_LIMIT_EN     0
`define BFP_CTRL_HOLD_OFF     1
`define BFP_CTRL_W            2
`define BFP_CTRL_RESET        2'h1

// Status register fields
`define BFP_ST_SHUTDOWN       0
`define BFP_ST_WARNING        1
`define BFP_ST_THERM_LATCH    2
`define BFP_ST_UNDERVOLT      3
`define BFP_ST_OVERLOAD_A     4
`define BFP_ST_OVERLOAD_B     5
`define BFP_ST_LIMIT_A        6
`define BFP_ST_LIMIT_B        7
`define BFP_ST_BRIDGE_RESET   8

// AXI responses
`define BFP_RESP_OKAY         2'h0
`define BFP_RESP_SLVERR       2'h2

// Overload persistence time and the clock that counts it
`define BFP_CLK_HZ            20000000
`define BFP_OLP_TIME_NS       1300000
`define BFP_OLP_CYCLES        ((`BFP_OLP_TIME_NS * (`BFP_CLK_HZ / 1000000)) / 1000)
`define BFP_OLP_CNT_W         16

`endif

// ==== common/bfp_pkg.sv ====
// Types shared by the bridge fault-protection design files.
// Assumes bfp_defs.svh is on the include path.
`include "bfp_defs.svh"

package bfp_pkg;

    // Asynchronous inputs from pins and analog comparators
    typedef struct packed {
        logic       bridgeResetN;
        logic [1:0] pwm;
        logic [1:0] tripHigh;
        logic [1:0] tripLow;
        logic       tempAboveWarn;
        logic       tempBelowWarnHyst;
        logic       tempAboveError;
        logic [1:0] gateSupplyOk;
        logic       logicRailOk;
    } bfp_pin_in_type;

    // Power-stage gate commands, one bit per half-bridge
    typedef struct packed {
        logic [1:0] highOn;
        logic [1:0] lowOn;
        logic [1:0] pulldownOn;
    } bfp_gate_type;

    // Open-drain status pin as out/enable
    typedef struct packed {
        logic out;
        logic oe;
    } bfp_od_type;

    typedef struct packed {
        logic                   awvalid;
        logic [`BFP_ADDR_W-1:0] awaddr;
        logic                   wvalid;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bready;
        logic                   arvalid;
        logic [`BFP_ADDR_W-1:0] araddr;
        logic                   rready;
    } bfp_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } bfp_axi_rsp_type;

endpackage

// ==== design/bfp_sync.sv ====
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no multi-bit coherence is implied.
`timescale 1ns/1ps
`default_nettype none

module bfp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    // Data
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } bfp_sync_state_type;

    bfp_sync_state_type state_q;
    bfp_sync_state_type state_d;

    generate
        if (W < 1) begin : g_bad_width
            $error("bfp_sync width must be at least one");
        end
    endgenerate

    always_comb begin
        state_d        = state_q;
        state_d.meta   = asyncIn;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stable;
endmodule // bfp_sync

`default_nettype wire

// ==== design/bfp_half_bridge.sv ====
// Overload tracker for one half-bridge: current-limit flag and latched
// overload shutdown after a trip persists for the set number of cycles.
// Assumes trip inputs are already synchronised to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "bfp_defs.svh"

module bfp_half_bridge #(
    parameter int CNT_W      = `BFP_OLP_CNT_W,
    parameter int OLP_CYCLES = `BFP_OLP_CYCLES
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Detector inputs and clear
    input  wire logic             tripHigh,
    input  wire logic             tripLow,
    input  wire logic             clearPulse,
    // Tracker state
    output logic                  limiting,
    output logic                  overloadLatch,
    output logic      [CNT_W-1:0] persistCount
);
    import bfp_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             limit;
        logic             overload;
    } bfp_hb_state_type;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(OLP_CYCLES - 1);

    bfp_hb_state_type state_q;
    bfp_hb_state_type state_d;

    generate
        if (OLP_CYCLES < 1 || OLP_CYCLES > (2 ** CNT_W)) begin : g_bad_count
            $error("bfp_half_bridge OLP_CYCLES does not fit CNT_W");
        end
    endgenerate

    always_comb begin
        state_d       = state_q;
        state_d.limit = tripHigh | tripLow;
        // Clear first; a trip held at the limit sets it again
        if (clearPulse) begin
            state_d.count    = '0;
            state_d.overload = 1'b0;
        end
        if (tripHigh || tripLow) begin
            if (state_q.count == LAST) begin
                state_d.overload = 1'b1;
            end else begin
                state_d.count = state_q.count + CNT_W'(1);
            end
        end else begin
            state_d.count = '0;
        end
    end

    // Power-on clear empties the tracker
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign limiting      = state_q.limit;
    assign overloadLatch = state_q.overload;
    assign persistCount  = state_q.count;
endmodule // bfp_half_bridge

`default_nettype wire

// ==== design/bfp_top.sv ====
// Fault protection and status reporting for a two-half-bridge power stage,
// with an AXI4-Lite register slave.
// Assumes analog comparators and supply monitors arrive as asynchronous
// levels, and that reset_n is the power-on clear.
`timescale 1ns/1ps
`default_nettype none
`include "bfp_defs.svh"

module bfp_top #(
    parameter int CNT_W      = `BFP_OLP_CNT_W,
    parameter int OLP_CYCLES = `BFP_OLP_CYCLES
) (
    // Clock and power-on reset
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,

    // Pins and comparators
    input  wire bfp_pkg::bfp_pin_in_type  pinIn,

    // Power-stage gates
    output bfp_pkg::bfp_gate_type         gate,

    // Status pins
    output bfp_pkg::bfp_od_type           fault_shutdown_n,
    output bfp_pkg::bfp_od_type           thermal_warning_n,

    // Register bus
    input  wire bfp_pkg::bfp_axi_req_type axiReq,
    output bfp_pkg::bfp_axi_rsp_type      axiRsp
);
    import bfp_pkg::*;

    typedef struct packed {
        // Register slave
        bfp_axi_rsp_type          rsp;
        logic                     awHeld;
        logic                     wHeld;
        logic [`BFP_ADDR_W-1:0]   awAddr;
        logic [31:0]              wData;
        logic [3:0]               wStrb;
        logic [`BFP_CTRL_W-1:0]   control;

        // Protection state
        logic                     bridgeRstPrev;
        logic                     warning;
        logic                     thermalErrorLatch;
        logic                     undervolt;
        logic                     shutdown;

        // Pins
        bfp_gate_type             gate;
        bfp_od_type               sdPin;
        bfp_od_type               warnPin;
    } bfp_top_state_type;

    bfp_top_state_type state_q;
    bfp_top_state_type state_d;

    bfp_pin_in_type   pinSync;

    logic [1:0]       limiting;
    logic [1:0]       overloadLatch;
    logic [CNT_W-1:0] persistA;
    logic [CNT_W-1:0] persistB;
    logic             bridgeRise;

    localparam bfp_top_state_type RESET_STATE = '{
        rsp:     '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
        control: `BFP_CTRL_RESET,
        sdPin:   '{out: 1'b0, oe: 1'b1},
        default: '0
    };

    generate
        if (CNT_W > 32) begin : g_bad_cnt_w
            $error("bfp_top CNT_W must not exceed the 32-bit register");
        end
    endgenerate

    // All pin inputs cross into sys_clk before any logic reads them
    bfp_sync #(
        .W ($bits(bfp_pin_in_type))
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .asyncIn (pinIn),
        .syncOut (pinSync)
    );

    assign bridgeRise = pinSync.bridgeResetN & ~state_q.bridgeRstPrev;

    // Half-bridge A
    bfp_half_bridge #(
        .CNT_W      (CNT_W),
        .OLP_CYCLES (OLP_CYCLES)
    ) u_hb_a (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .tripHigh      (pinSync.tripHigh[0]),
        .tripLow       (pinSync.tripLow[0]),
        .clearPulse    (bridgeRise),
        .limiting      (limiting[0]),
        .overloadLatch (overloadLatch[0]),
        .persistCount  (persistA)
    );

    // Half-bridge B
    bfp_half_bridge #(
        .CNT_W      (CNT_W),
        .OLP_CYCLES (OLP_CYCLES)
    ) u_hb_b (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .tripHigh      (pinSync.tripHigh[1]),
        .tripLow       (pinSync.tripLow[1]),
        .clearPulse    (bridgeRise),
        .limiting      (limiting[1]),
        .overloadLatch (overloadLatch[1]),
        .persistCount  (persistB)
    );

    // Register read decode
    function automatic logic [32:0] read_reg(
        input logic [`BFP_ADDR_W-1:0] addr,
        input bfp_top_state_type      s,
        input logic [1:0]             lim,
        input logic [1:0]             ovl,
        input logic                   rstLevel,
        input logic [CNT_W-1:0]       cntA,
        input logic [CNT_W-1:0]       cntB
    );
        logic [31:0] data;
        logic        hit;

        data = '0;
        hit  = 1'b1;
        case (addr)
            `BFP_REG_CONTROL: begin
                data[`BFP_CTRL_W-1:0] = s.control;
            end

            `BFP_REG_STATUS: begin
                data[`BFP_ST_SHUTDOWN]     = s.shutdown;
                data[`BFP_ST_WARNING]      = s.warning;
                data[`BFP_ST_THERM_LATCH]  = s.thermalErrorLatch;
                data[`BFP_ST_UNDERVOLT]    = s.undervolt;
                data[`BFP_ST_OVERLOAD_A]   = ovl[0];
                data[`BFP_ST_OVERLOAD_B]   = ovl[1];
                data[`BFP_ST_LIMIT_A]      = lim[0];
                data[`BFP_ST_LIMIT_B]      = lim[1];
                data[`BFP_ST_BRIDGE_RESET] = rstLevel;
            end

            `BFP_REG_OVERLOAD_CNT: begin
                data = 32'(cntA > cntB ? cntA : cntB);
            end

            default: begin
                hit = 1'b0;
            end
        endcase

        return {hit, data};
    endfunction

    always_comb begin
        logic        anyShutdown;
        logic        hiZ;
        logic [32:0] rd;
        logic        wrHit;

        anyShutdown = 1'b0;
        hiZ         = 1'b0;
        rd          = '0;
        wrHit       = 1'b0;
        state_d     = state_q;

        state_d.bridgeRstPrev = pinSync.bridgeResetN;

        // Warning with hysteresis
        if (pinSync.tempAboveWarn) begin
            state_d.warning = 1'b1;
        end else if (pinSync.tempBelowWarnHyst) begin
            state_d.warning = 1'b0;
        end

        // Overtemperature error latch; a still-hot die sets it over the clear
        if (bridgeRise) begin
            state_d.thermalErrorLatch = 1'b0;
        end

        if (pinSync.tempAboveError) begin
            state_d.thermalErrorLatch = 1'b1;
        end

        // Undervoltage follows the monitors without latching
        state_d.undervolt = ~(&pinSync.gateSupplyOk & pinSync.logicRailOk);

        anyShutdown = state_d.thermalErrorLatch
                    | (|overloadLatch)
                    | state_d.undervolt;

        state_d.shutdown = anyShutdown;

        // Status pins pull low to assert, release otherwise
        state_d.sdPin.out   = 1'b0;
        state_d.sdPin.oe    = anyShutdown;

        state_d.warnPin.out = 1'b0;
        state_d.warnPin.oe  = state_d.warning;

        // Gate drive
        hiZ = ~pinSync.bridgeResetN
            | anyShutdown
            | state_q.control[`BFP_CTRL_HOLD_OFF];

        for (int i = 0; i < 2; i++) begin
            state_d.gate.pulldownOn[i] = ~pinSync.bridgeResetN;

            if (hiZ) begin
                state_d.gate.highOn[i] = 1'b0;
                state_d.gate.lowOn[i]  = 1'b0;
            end else begin
                state_d.gate.highOn[i] = pinSync.pwm[i];
                state_d.gate.lowOn[i]  = ~pinSync.pwm[i];

                if (state_q.control[`BFP_CTRL_LIMIT_EN]) begin
                    if (pinSync.tripHigh[i]) begin
                        state_d.gate.highOn[i] = 1'b0;
                    end

                    if (pinSync.tripLow[i]) begin
                        state_d.gate.lowOn[i] = 1'b0;
                    end
                end
            end
        end

        // Write channel: address and data taken in either order
        if (axiReq.awvalid && state_q.rsp.awready) begin
            state_d.awHeld      = 1'b1;
            state_d.awAddr      = axiReq.awaddr;
            state_d.rsp.awready = 1'b0;
        end

        if (axiReq.wvalid && state_q.rsp.wready) begin
            state_d.wHeld      = 1'b1;
            state_d.wData      = axiReq.wdata;
            state_d.wStrb      = axiReq.wstrb;
            state_d.rsp.wready = 1'b0;
        end

        // Both halves held
        if (state_q.awHeld && state_q.wHeld && !state_q.rsp.bvalid) begin
            wrHit = 1'b1;
            case (state_q.awAddr)
                `BFP_REG_CONTROL: begin
                    if (state_q.wStrb[0]) begin
                        state_d.control = state_q.wData[`BFP_CTRL_W-1:0];
                    end
                end

                `BFP_REG_STATUS, `BFP_REG_OVERLOAD_CNT: begin
                    wrHit = 1'b1;
                end

                default: begin
                    wrHit = 1'b0;
                end
            endcase

            state_d.rsp.bvalid = 1'b1;
            state_d.rsp.bresp  = wrHit ? `BFP_RESP_OKAY : `BFP_RESP_SLVERR;
            state_d.awHeld     = 1'b0;
            state_d.wHeld      = 1'b0;
        end

        // Reopen after answer
        if (state_q.rsp.bvalid && axiReq.bready) begin
            state_d.rsp.bvalid  = 1'b0;
            state_d.rsp.awready = 1'b1;
            state_d.rsp.wready  = 1'b1;
        end

        // Read channel
        if (axiReq.arvalid && state_q.rsp.arready) begin
            rd = read_reg(axiReq.araddr, state_q, limiting, overloadLatch,
                          pinSync.bridgeResetN, persistA, persistB);

            state_d.rsp.arready = 1'b0;
            state_d.rsp.rvalid  = 1'b1;
            state_d.rsp.rdata   = rd[31:0];
            state_d.rsp.rresp   = rd[32] ? `BFP_RESP_OKAY : `BFP_RESP_SLVERR;
        end

        // Read answer taken
        if (state_q.rsp.rvalid && axiReq.rready) begin
            state_d.rsp.rvalid  = 1'b0;
            state_d.rsp.arready = 1'b1;
        end
    end

    // Power-on clear: gates off, shutdown pin pulled low until monitors settle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= RESET_STATE;
        end else begin
            state_q <= state_d;
        end
    end

    assign gate              = state_q.gate;
    assign fault_shutdown_n  = state_q.sdPin;
    assign thermal_warning_n = state_q.warnPin;
    assign axiRsp            = state_q.rsp;
endmodule // bfp_top

`default_nettype wire

// ==== test/bfp_top_assertions.sv ====
// Checker for the bridge fault-protection top: status pins, gate safety, latches.
// Assumes it is bound to bfp_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module bfp_top_assertions #(
    parameter int CNT_W      = 16,
    parameter int OLP_CYCLES = 26000
) (
    // Clock and reset
    input wire logic                     sys_clk,
    input wire logic                     reset_n,
    // Observed ports
    input wire bfp_pkg::bfp_pin_in_type  pinIn,
    input wire bfp_pkg::bfp_gate_type    gate,
    input wire bfp_pkg::bfp_od_type      fault_shutdown_n,
    input wire bfp_pkg::bfp_od_type      thermal_warning_n,
    input wire bfp_pkg::bfp_axi_req_type axiReq,
    input wire bfp_pkg::bfp_axi_rsp_type axiRsp
);
    import bfp_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic        supOk;
    logic        calm;
    logic        gatesOff;
    logic [15:0] tripRun_q;
    assign supOk    = (&pinIn.gateSupplyOk) & pinIn.logicRailOk;
    assign calm     = supOk & ~pinIn.tempAboveError & ~|{pinIn.tripHigh, pinIn.tripLow};
    assign gatesOff = ({gate.highOn, gate.lowOn} == 4'h0);
    // Consecutive trip cycles on half-bridge B with bridge reset released
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) tripRun_q <= 16'h0000;
        else if (pinIn.bridgeResetN && (pinIn.tripHigh[1] || pinIn.tripLow[1]))
            tripRun_q <= tripRun_q + 16'h0001;
        else tripRun_q <= 16'h0000;
    end
    sequence s_bridge_rise;
        ($rose(pinIn.bridgeResetN) && calm) ##1 (pinIn.bridgeResetN && calm)[*6];
    endsequence
    sequence s_error_gone;
        (pinIn.bridgeResetN[*3] ##0 pinIn.tempAboveError)
            ##1 (pinIn.bridgeResetN && !pinIn.tempAboveError)[*6];
    endsequence
    AST_OD_LEVEL: assert property (fault_shutdown_n.out == 1'b0 && thermal_warning_n.out == 1'b0)
        else $error("status pin drives a high level");
    AST_RESET_HIZ: assert property ((!pinIn.bridgeResetN)[*5] |-> gatesOff && gate.pulldownOn == 2'h3)
        else $error("bridge reset low without Hi-Z and pulldown");
    AST_UV_SHUT: assert property ((!supOk)[*5] |-> fault_shutdown_n.oe && gatesOff)
        else $error("undervoltage without shutdown");
    AST_WARN_SET: assert property (pinIn.tempAboveWarn[*5] |-> thermal_warning_n.oe)
        else $error("hot without warning");
    AST_WARN_HOLD: assert property ((!pinIn.tempBelowWarnHyst)[*4] ##0 $past(thermal_warning_n.oe)
        |-> thermal_warning_n.oe)
        else $error("warning released before cooling");
    AST_ERR_SHUT: assert property (pinIn.tempAboveError[*5] |-> fault_shutdown_n.oe && gatesOff)
        else $error("error temperature without shutdown");
    AST_ERR_LATCH: assert property (s_error_gone |-> fault_shutdown_n.oe)
        else $error("thermal error not latched");
    AST_BRIDGE_CLEAR: assert property (s_bridge_rise |-> !fault_shutdown_n.oe)
        else $error("bridge reset rise left shutdown");
    AST_OVERLOAD_B: assert property (tripRun_q == OLP_CYCLES + 8 |-> fault_shutdown_n.oe)
        else $error("persisting trip without overload shutdown");
    AST_NO_SHOOT: assert property ((gate.highOn & gate.lowOn) == 2'h0)
        else $error("both transistors of a half-bridge on");
endmodule // bfp_top_assertions
bind bfp_top bfp_top_assertions #(.CNT_W(CNT_W), .OLP_CYCLES(OLP_CYCLES)) bfp_top_assertions_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .pinIn(pinIn), .gate(gate),
    .fault_shutdown_n(fault_shutdown_n), .thermal_warning_n(thermal_warning_n),
    .axiReq(axiReq), .axiRsp(axiRsp));
`default_nettype wire

// ==== test/bfp_ctrl_model.sv ====
// Controller model on the far side: drives bridge reset and PWM, reads status.
// Assumes status pins have a pull-up; the bench asks for power and clear pulses.
`timescale 1ns/1ps
`default_nettype none
module bfp_ctrl_model (
    // Clock
    input  wire logic                sys_clk,
    // Requests from the bench
    input  wire logic                powerGood,
    input  wire logic                clearReq,
    input  wire logic [1:0]          pwmReq,
    // Status pins
    input  wire bfp_pkg::bfp_od_type fault_shutdown_n,
    input  wire bfp_pkg::bfp_od_type thermal_warning_n,
    // Toward the block and pin levels
    output logic                     bridgeResetN,
    output logic [1:0]               pwm,
    output logic                     shutdownLevel,
    output logic                     warningLevel
);
    import bfp_pkg::*;
    // Pull-up wins when nothing drives the pin
    assign shutdownLevel = fault_shutdown_n.oe ? fault_shutdown_n.out : 1'b1;
    assign warningLevel  = thermal_warning_n.oe ? thermal_warning_n.out : 1'b1;
    initial begin
        bridgeResetN = 1'b0;
        pwm          = 2'h0;
    end
    always @(posedge sys_clk) begin
        bridgeResetN <= powerGood & ~clearReq;
        pwm          <= warningLevel ? pwmReq : 2'h0;
    end
endmodule // bfp_ctrl_model
`default_nettype wire

// ==== test/tb.sv ====
// Bench for the bridge fault-protection top: power-up, registers, PWM, faults.
// Assumes the controller model on the far side and a short overload count.
`timescale 1ns/1ps
`default_nettype none
`include "bfp_defs.svh"
module tb;
    import bfp_pkg::*;
    logic            sys_clk;
    logic            reset_n;
    bfp_pin_in_type  env;
    bfp_pin_in_type  pinIn;
    bfp_gate_type    gate;
    bfp_od_type      sdPin;
    bfp_od_type      owPin;
    bfp_axi_req_type req;
    bfp_axi_rsp_type rsp;
    logic            powerGood;
    logic            clearReq;
    logic [1:0]      pwmReq;
    logic            ctlRstN;
    logic [1:0]      ctlPwm;
    logic            sdLvl;
    logic            owLvl;
    logic [31:0]     rd;
    logic [1:0]      resp;
    int              n_fail;
    int              checks;

    bfp_top #(.OLP_CYCLES(8)) bfp_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .pinIn(pinIn),
        .gate(gate), .fault_shutdown_n(sdPin), .thermal_warning_n(owPin), .axiReq(req),
        .axiRsp(rsp));
    bfp_ctrl_model bfp_ctrl_model_i (.sys_clk(sys_clk), .powerGood(powerGood),
        .clearReq(clearReq), .pwmReq(pwmReq), .fault_shutdown_n(sdPin),
        .thermal_warning_n(owPin), .bridgeResetN(ctlRstN), .pwm(ctlPwm),
        .shutdownLevel(sdLvl), .warningLevel(owLvl));

    always_comb begin
        pinIn              = env;
        pinIn.bridgeResetN = ctlRstN;
        pinIn.pwm          = ctlPwm;
    end
    always #25 sys_clk = ~sys_clk;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        resp = rsp.bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rd   = rsp.rdata;
        resp = rsp.rresp;
    endtask
    task automatic pulse_clear();
        clearReq <= 1'b1;
        cyc(2);
        clearReq <= 1'b0;
        cyc(8);
    endtask
    task automatic t_power();
        cyc(5);
        chk("sd at power-up", sdPin.oe, 1'b1);
        chk("pulldown", gate.pulldownOn, 2'h3);
        env.gateSupplyOk      <= 2'h3;
        env.logicRailOk       <= 1'b1;
        env.tempBelowWarnHyst <= 1'b1;
        cyc(5);
        chk("gates in reset", {gate.highOn, gate.lowOn}, 4'h0);
        powerGood <= 1'b1;
        cyc(5);
        chk("pins after power", {sdLvl, owLvl}, 2'h3);
        chk("pulldown off", gate.pulldownOn, 2'h0);
        $display("test power done");
    endtask
    task automatic t_regs();
        axi_rd(`BFP_REG_CONTROL);
        chk("control reset", rd, {30'h0, `BFP_CTRL_RESET});
        axi_wr(`BFP_REG_CONTROL, 32'h0000_0003);
        cyc(5);
        chk("hold-off gates", {gate.highOn, gate.lowOn, sdPin.oe}, 5'h00);
        axi_wr(`BFP_REG_CONTROL, 32'h0000_0001);
        axi_wr(`BFP_REG_STATUS, 32'hFFFF_FFFF);
        chk("status write resp", resp, `BFP_RESP_OKAY);
        axi_rd(`BFP_REG_STATUS);
        chk("status idle", rd, 32'h0000_0100);
        axi_rd(8'h0C);
        chk("unmapped read", {resp, rd[29:0]}, {`BFP_RESP_SLVERR, 30'h0});
        axi_wr(8'h0C, 32'h1);
        chk("unmapped write", resp, `BFP_RESP_SLVERR);
        $display("test registers done");
    endtask
    task automatic t_pwm_limit();
        for (int p = 0; p < 4; p++) begin
            pwmReq <= p[1:0];
            cyc(5);
            chk("follow", {gate.highOn, gate.lowOn}, {p[1:0], ~p[1:0]});
        end
        for (int k = 0; k < 2; k++) begin
            pwmReq <= k ? 2'h0 : 2'h3;
            cyc(5);
            if (k) env.tripLow <= 2'h2;
            else env.tripHigh <= 2'h1;
            cyc(5);
            chk("limit", {gate.highOn, gate.lowOn, sdPin.oe}, k ? 5'h02 : 5'h10);
            env.tripLow  <= 2'h0;
            env.tripHigh <= 2'h0;
        end
        $display("test pwm and limit done");
    endtask
    task automatic t_overload();
        pwmReq      <= 2'h3;
        env.tripLow <= 2'h2;
        cyc(20);
        chk("overload pins", {sdLvl, owLvl}, 2'h1);
        axi_rd(`BFP_REG_STATUS);
        chk("overload B only", rd[5:4], 2'h2);
        env.tripLow <= 2'h0;
        cyc(10);
        chk("overload latched", {sdLvl, gate.highOn, gate.lowOn}, 5'h00);
        pulse_clear();
        chk("overload cleared", {sdLvl, gate.highOn}, 3'h7);
        $display("test overload done");
    endtask
    task automatic t_thermal();
        env.tempAboveWarn     <= 1'b1;
        env.tempBelowWarnHyst <= 1'b0;
        cyc(5);
        chk("warning", {sdLvl, owLvl}, 2'h2);
        env.tempAboveWarn <= 1'b0;
        cyc(6);
        chk("warning held", owLvl, 1'b0);
        env.tempAboveError <= 1'b1;
        cyc(5);
        chk("thermal shutdown", {sdLvl, owLvl, gate.highOn, gate.lowOn}, 6'h00);
        env.tempAboveError <= 1'b0;
        cyc(10);
        chk("thermal latched", sdLvl, 1'b0);
        pulse_clear();
        chk("thermal cleared", sdLvl, 1'b1);
        env.tempBelowWarnHyst <= 1'b1;
        cyc(5);
        chk("warning released", owLvl, 1'b1);
        $display("test thermal done");
    endtask
    task automatic t_uv();
        for (int k = 0; k < 3; k++) begin
            env.gateSupplyOk <= (k == 0) ? 2'h2 : (k == 1) ? 2'h1 : 2'h3;
            env.logicRailOk  <= (k != 2);
            cyc(5);
            chk("uv shutdown", {sdLvl, owLvl, gate.highOn, gate.lowOn}, 6'h10);
            env.gateSupplyOk <= 2'h3;
            env.logicRailOk  <= 1'b1;
            cyc(6);
            chk("uv recovered", {sdLvl, gate.highOn}, 3'h7);
        end
        $display("test undervoltage done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_clk     = 1'b0;
        reset_n     = 1'b0;
        env         = '0;
        powerGood   = 1'b0;
        clearReq    = 1'b0;
        pwmReq      = 2'h0;
        req         = '0;
        req.wstrb   = 4'hF;
        req.bready  = 1'b1;
        req.rready  = 1'b1;
        n_fail      = 0;
        checks      = 0;
        cyc(20);
        reset_n <= 1'b1;
        t_power();
        t_regs();
        t_pwm_limit();
        t_overload();
        t_thermal();
        t_uv();
        close_out();
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        n_fail++;
        close_out();
    end
endmodule // tb
`default_nettype wire
